// ### logic/tpw_defines.svh
// register offsets, field positions, reset values and mode codes of the pwm timer
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH

// byte offsets of the word registers
`define TPW_OFF_CTRL      5'h00
`define TPW_OFF_COUNT     5'h04
`define TPW_OFF_CMPA      5'h08
`define TPW_OFF_CMPB      5'h0c
`define TPW_OFF_CAPTOP    5'h10
`define TPW_OFF_FLAGS     5'h14
`define TPW_OFF_STATUS    5'h18

// flag bit positions
`define TPW_FLG_OVF       0
`define TPW_FLG_CMPA      1
`define TPW_FLG_CMPB      2
`define TPW_FLG_CAP       3

// status bit positions
`define TPW_ST_OC_LSB     0
`define TPW_ST_DOWN       2

// reset values
`define TPW_RST_CTRL      10'h000
`define TPW_RST_WORD      16'h0000
`define TPW_RST_CAPTOP    16'hffff

// fixed tops and the lowest legal register top
`define TPW_TOP_8BIT      16'h00ff
`define TPW_TOP_9BIT      16'h01ff
`define TPW_TOP_10BIT     16'h03ff
`define TPW_TOP_MIN       16'h0003

// waveform mode codes
`define TPW_M_PC8         4'h1
`define TPW_M_PC9         4'h2
`define TPW_M_PC10        4'h3
`define TPW_M_FAST8       4'h5
`define TPW_M_FAST9       4'h6
`define TPW_M_FAST10      4'h7
`define TPW_M_PC_CAP      4'ha
`define TPW_M_PC_CMPA     4'hb
`define TPW_M_FAST_CAP    4'he
`define TPW_M_FAST_CMPA   4'hf

// compare output selector codes
`define TPW_SEL_NONE      2'h0
`define TPW_SEL_TOGGLE    2'h1
`define TPW_SEL_INV       2'h3

`endif

// ### logic/tpw_pkg.sv
// types shared by the pwm timer
package tpw_pkg;

    // control register fields, mode in the low bits
    typedef struct packed {
        logic [1:0] pin_direction_bit;
        logic [1:0] channel_b_output_select;
        logic [1:0] channel_a_output_select;
        logic [3:0] waveform_mode_select;
    } tpw_ctrl_t;

    // sticky event flags
    typedef struct packed {
        logic capture_flag;
        logic compare_b_match_flag;
        logic compare_a_match_flag;
        logic overflow_flag;
    } tpw_flags_t;

    // counting direction of the dual-slope modes
    typedef enum logic [1:0] {
        TPW_SLOPE_UP   = 2'b01,
        TPW_SLOPE_DOWN = 2'b10
    } tpw_slope_t;

endpackage : tpw_pkg

// ### logic/tpw_timer16.sv
// 16-bit timer with fast and phase correct pwm, behind an avalon-mm slave
//
// Behaviour
// R1 - fast modes 5,6,7,14,15 count single-slope from zero up to top, then restart
// R2 - fast non-inverting clears on match, sets at bottom; inverting does the opposite
// R3 - fast top is 0x00FF/0x01FF/0x03FF, capture or compare a; clear after top
// R4 - fast overflow flag at top, with compare-a or capture flag when defining top
// R5 - compare a writes go to a buffer copied to active value at top
// R6 - capture top is unbuffered; written below count, counter wraps through 0xFFFF
// R7 - fixed-top modes force compare bits above the resolution to zero on write
// R8 - resolution 2 to 16 bits; software keeps register top at least 0x0003
// R9 - output selector two gives non-inverted pwm, three gives inverted pwm
// R10 - fast compare zero gives one-tick spike; compare at top gives constant level
// R11 - fast mode selector one toggles channel a on match, buffering kept
// R12 - phase correct modes 1,2,3,10,11 count up to top and back to zero
// R13 - phase correct non-inverting clears on up match, sets on down match
// R14 - phase correct top fixed, capture or compare a; top held one tick
// R15 - phase correct overflow at zero; buffers load at top with top flag
// R16 - phase correct compare zero holds low, compare top holds high, inverted opposite
// R17 - software changing top while running should prefer frequency correct mode
// R18 - output selector zero takes no action on the output state at match
// R19 - software keeps top above all compares and sets pin direction to output
// R20 - each channel sets its match flag on every match in both pwm families
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns

`include "tpw_defines.svh"

module tpw_timer16 (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    // prescaled timer tick from the same clock domain
    input  wire logic               timer_tick,
    // avalon-mm slave
    input  wire logic [4:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    // compare output pins, channel a in bit 0
    output logic [1:0]              pin_out,
    output logic [1:0]              pin_oe_n,
    // register views for the checkers and the bench
    output tpw_pkg::tpw_ctrl_t      ctrl_state,
    output tpw_pkg::tpw_flags_t     flag_state
);
    import tpw_pkg::*;

    // registers
    tpw_ctrl_t          ctrl_ff;
    tpw_ctrl_t          nxt_ctrl;
    logic [15:0]        count_value_ff;
    logic [15:0]        nxt_count_value;
    tpw_slope_t         slope_ff;
    tpw_slope_t         nxt_slope;
    logic [15:0]        cmpa_buf_ff;
    logic [15:0]        nxt_cmpa_buf;
    logic [15:0]        cmpb_buf_ff;
    logic [15:0]        nxt_cmpb_buf;
    logic [15:0]        compare_a_value_ff;
    logic [15:0]        nxt_compare_a_value;
    logic [15:0]        compare_b_value_ff;
    logic [15:0]        nxt_compare_b_value;
    logic [15:0]        capture_top_value_ff;
    logic [15:0]        nxt_capture_top_value;
    tpw_flags_t         flags_ff;
    tpw_flags_t         nxt_flags;
    logic [1:0]         oc_state_ff;
    logic [1:0]         nxt_oc_state;
    logic               ack_ff;
    logic               nxt_ack;
    logic [31:0]        rdata_ff;
    logic [31:0]        nxt_rdata;

    // decoded mode
    logic               fast_mode;
    logic               pc_mode;
    logic               top_from_a;
    logic               top_from_cap;
    logic               fixed_top;
    logic [15:0]        top_value;

    // bus decode
    logic               bus_req;
    logic               bus_wr;
    logic [31:0]        wr_word;

    // counter events
    logic               at_top;
    logic               at_bottom;
    logic               wrap_tick;
    logic               reload;
    logic               ev_ovf;
    logic               ev_top_a;
    logic               ev_top_cap;
    logic [1:0]         match;
    logic [15:0]        cmp_act [2];
    logic [1:0]         sel [2];

    // merge write data into the old word under byteenable
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_word;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_word[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // next output state of one channel on a timer tick
    function automatic logic oc_next(
        input logic       cur,
        input logic [1:0] osel,
        input logic       hit,
        input logic       is_a,
        input logic       fast,
        input logic       pcor,
        input logic       bottom,
        input logic       going_down
    );
        logic inv;
        logic r;
        inv = (osel == `TPW_SEL_INV);
        r   = cur;
        if (fast) begin
            if (osel[1]) begin
                // R2 bottom set
                // bottom beats a match at top, so compare equal to top stays constant
                if (bottom) begin
                    r = !inv;
                end else if (hit) begin
                    r = inv;
                end
            // R11 toggle on match
            end else if (osel == `TPW_SEL_TOGGLE && is_a && hit) begin
                r = !cur;
            end
        end else if (pcor && osel[1] && hit) begin
            // R13 slope-dependent action
            // judged by the slope after the tick: a match at zero clears, at top sets
            r = going_down ? !inv : inv;
        end
        return r;
    endfunction : oc_next

    // mode decode and top selection
    always_comb begin
        fast_mode    = 1'b0;
        pc_mode      = 1'b0;
        top_from_a   = 1'b0;
        top_from_cap = 1'b0;
        fixed_top    = 1'b0;
        top_value    = 16'hffff;
        unique case (ctrl_ff.waveform_mode_select)
            // R3 fixed tops of the fast modes
            `TPW_M_FAST8: {fast_mode, fixed_top, top_value} = {2'b11, `TPW_TOP_8BIT};
            `TPW_M_FAST9: {fast_mode, fixed_top, top_value} = {2'b11, `TPW_TOP_9BIT};
            `TPW_M_FAST10: {fast_mode, fixed_top, top_value} = {2'b11, `TPW_TOP_10BIT};
            // R6 capture register as top, unbuffered
            `TPW_M_FAST_CAP: {fast_mode, top_from_cap, top_value} = {2'b11, capture_top_value_ff};
            // R8 full 16-bit register top
            `TPW_M_FAST_CMPA: {fast_mode, top_from_a, top_value} = {2'b11, compare_a_value_ff};
            // R14 tops of the phase correct modes
            `TPW_M_PC8: {pc_mode, fixed_top, top_value} = {2'b11, `TPW_TOP_8BIT};
            `TPW_M_PC9: {pc_mode, fixed_top, top_value} = {2'b11, `TPW_TOP_9BIT};
            `TPW_M_PC10: {pc_mode, fixed_top, top_value} = {2'b11, `TPW_TOP_10BIT};
            `TPW_M_PC_CAP: {pc_mode, top_from_cap, top_value} = {2'b11, capture_top_value_ff};
            `TPW_M_PC_CMPA: {pc_mode, top_from_a, top_value} = {2'b11, compare_a_value_ff};
            // other modes are not built here: the counter stands still
            default: fast_mode = 1'b0;
        endcase
    end

    // bus handshake: every access waits exactly one cycle
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_ff;
    assign nxt_ack         = bus_req & ~ack_ff;
    assign bus_wr          = avs_write & ack_ff;

    // R7 mask writes above a fixed resolution
    assign wr_word = merge_bytes(32'h0000_0000, avs_writedata, avs_byteenable)
                     & (fixed_top ? {16'h0000, top_value} : 32'h0000_ffff);

    // control and capture registers, flags with write-one-to-clear
    always_comb begin
        nxt_ctrl              = ctrl_ff;
        nxt_capture_top_value = capture_top_value_ff;
        nxt_cmpa_buf          = cmpa_buf_ff;
        nxt_cmpb_buf          = cmpb_buf_ff;
        nxt_flags             = flags_ff;
        if (bus_wr) begin
            unique case (avs_address)
                `TPW_OFF_CTRL: begin
                    nxt_ctrl = tpw_ctrl_t'(10'(merge_bytes({22'h00_0000, ctrl_ff}, avs_writedata,
                                                           avs_byteenable)));
                end
                `TPW_OFF_CAPTOP: begin
                    nxt_capture_top_value = 16'(merge_bytes({16'h0000, capture_top_value_ff},
                                                            avs_writedata, avs_byteenable));
                end
                // R5 compare writes land in the buffer
                `TPW_OFF_CMPA: begin
                    nxt_cmpa_buf = wr_word[15:0];
                end
                `TPW_OFF_CMPB: begin
                    nxt_cmpb_buf = wr_word[15:0];
                end
                `TPW_OFF_FLAGS: begin
                    nxt_flags = flags_ff & ~tpw_flags_t'(wr_word[3:0]);
                end
                default: begin
                    nxt_ctrl = ctrl_ff;
                end
            endcase
        end
        // a flag raised in the cycle of its clear stays set
        nxt_flags.overflow_flag        = nxt_flags.overflow_flag | ev_ovf;
        nxt_flags.compare_a_match_flag = nxt_flags.compare_a_match_flag | match[0] | ev_top_a;
        nxt_flags.compare_b_match_flag = nxt_flags.compare_b_match_flag | match[1];
        nxt_flags.capture_flag         = nxt_flags.capture_flag | ev_top_cap;
    end

    // counter, slope and double buffer update
    always_comb begin
        at_top              = (count_value_ff == top_value);
        at_bottom           = (count_value_ff == 16'h0000);
        nxt_count_value     = count_value_ff;
        nxt_slope           = slope_ff;
        nxt_compare_a_value = compare_a_value_ff;
        nxt_compare_b_value = compare_b_value_ff;
        wrap_tick           = 1'b0;
        reload              = 1'b0;
        ev_ovf              = 1'b0;
        if (timer_tick && fast_mode) begin
            // R1 single slope, R3 clear after top
            // a top below the count is missed; the add wraps through 0xffff
            nxt_count_value = at_top ? 16'h0000 : 16'(count_value_ff + 16'h0001);
            // R4 overflow at top
            wrap_tick = at_top;
            ev_ovf    = at_top;
            reload    = at_top;
        end else if (timer_tick && pc_mode) begin
            // R12 dual slope
            // R14 top held for one tick
            if (slope_ff == TPW_SLOPE_UP && at_top) begin
                nxt_slope = TPW_SLOPE_DOWN;
                reload    = 1'b1;
            end else if (slope_ff == TPW_SLOPE_DOWN && at_bottom) begin
                nxt_slope = TPW_SLOPE_UP;
                // R15 overflow at zero
                ev_ovf    = 1'b1;
            end
            nxt_count_value = (nxt_slope == TPW_SLOPE_DOWN) ? 16'(count_value_ff - 16'h0001)
                                                             : 16'(count_value_ff + 16'h0001);
        end
        // R5 copy buffers at top
        // outside the pwm families the buffers pass straight through
        if (reload || !(fast_mode || pc_mode)) begin
            nxt_compare_a_value = cmpa_buf_ff;
            nxt_compare_b_value = cmpb_buf_ff;
        end
        // software write to the count wins over counting
        if (bus_wr && avs_address == `TPW_OFF_COUNT) begin
            nxt_count_value = 16'(merge_bytes({16'h0000, count_value_ff}, avs_writedata,
                                              avs_byteenable));
        end
    end

    // R4 top flags ride with the reload
    // R15 same tick in the dual-slope modes
    assign ev_top_a   = reload & top_from_a;
    assign ev_top_cap = reload & top_from_cap;

    assign cmp_act[0] = compare_a_value_ff;
    assign cmp_act[1] = compare_b_value_ff;
    assign sel[0]     = ctrl_ff.channel_a_output_select;
    assign sel[1]     = ctrl_ff.channel_b_output_select;

    // per-channel match detect and output state
    for (genvar g = 0; g < 2; g++) begin : g_chan
        // R20 match flag on every match
        assign match[g] = timer_tick & (fast_mode | pc_mode) & (count_value_ff == cmp_act[g]);
        // R9 R10 R16 polarity and extreme values
        // R18 selector zero leaves the state alone
        assign nxt_oc_state[g] = (timer_tick && sel[g] != `TPW_SEL_NONE)
            ? oc_next(oc_state_ff[g], sel[g], match[g], (g == 0), fast_mode, pc_mode,
                      wrap_tick, nxt_slope == TPW_SLOPE_DOWN)
            : oc_state_ff[g];
        // the pin is driven only when the direction bit is set and a selector is active
        assign pin_oe_n[g] = ~(ctrl_ff.pin_direction_bit[g] & (sel[g] != `TPW_SEL_NONE));
    end

    // read data is captured while waitrequest is high
    always_comb begin
        nxt_rdata = rdata_ff;
        if (avs_read && !ack_ff) begin
            unique case (avs_address)
                `TPW_OFF_CTRL:   nxt_rdata = {22'h00_0000, ctrl_ff};
                `TPW_OFF_COUNT:  nxt_rdata = {16'h0000, count_value_ff};
                `TPW_OFF_CMPA:   nxt_rdata = {16'h0000, cmpa_buf_ff};
                `TPW_OFF_CMPB:   nxt_rdata = {16'h0000, cmpb_buf_ff};
                `TPW_OFF_CAPTOP: nxt_rdata = {16'h0000, capture_top_value_ff};
                `TPW_OFF_FLAGS:  nxt_rdata = {28'h000_0000, flags_ff};
                `TPW_OFF_STATUS: nxt_rdata = {29'h0000_0000, slope_ff == TPW_SLOPE_DOWN, oc_state_ff};
                default:         nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // register stage
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff              <= `TPW_RST_CTRL;
            count_value_ff       <= `TPW_RST_WORD;
            slope_ff             <= TPW_SLOPE_UP;
            cmpa_buf_ff          <= `TPW_RST_WORD;
            cmpb_buf_ff          <= `TPW_RST_WORD;
            compare_a_value_ff   <= `TPW_RST_WORD;
            compare_b_value_ff   <= `TPW_RST_WORD;
            capture_top_value_ff <= `TPW_RST_CAPTOP;
            flags_ff             <= '0;
            oc_state_ff          <= 2'h0;
            ack_ff               <= 1'b0;
            rdata_ff             <= 32'h0000_0000;
        end else begin
            ctrl_ff              <= nxt_ctrl;
            count_value_ff       <= nxt_count_value;
            slope_ff             <= nxt_slope;
            cmpa_buf_ff          <= nxt_cmpa_buf;
            cmpb_buf_ff          <= nxt_cmpb_buf;
            compare_a_value_ff   <= nxt_compare_a_value;
            compare_b_value_ff   <= nxt_compare_b_value;
            capture_top_value_ff <= nxt_capture_top_value;
            flags_ff             <= nxt_flags;
            oc_state_ff          <= nxt_oc_state;
            ack_ff               <= nxt_ack;
            rdata_ff             <= nxt_rdata;
        end
    end

    // outputs
    assign avs_readdata = rdata_ff;
    assign pin_out      = oc_state_ff;
    assign ctrl_state   = ctrl_ff;
    assign flag_state   = flags_ff;

endmodule : tpw_timer16

// ### tb/tpw_timer16_asserts.sv
// concurrent checks on the pwm timer ports
`timescale 1ns/1ns
`include "tpw_defines.svh"

module tpw_timer16_asserts
    import tpw_pkg::*;
(
    // clock and reset
    input wire logic                sys_clk,
    input wire logic                rstn,
    // tick and bus
    input wire logic                timer_tick,
    input wire logic [4:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_writedata,
    input wire logic [3:0]          avs_byteenable,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    // pins and register views
    input wire logic [1:0]          pin_out,
    input wire logic [1:0]          pin_oe_n,
    input wire tpw_pkg::tpw_ctrl_t  ctrl_state,
    input wire tpw_pkg::tpw_flags_t flag_state
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic fast_m;
    logic clr_ovf;
    // mode decode and software clear of the overflow flag
    assign fast_m  = ctrl_state.waveform_mode_select inside
                     {`TPW_M_FAST8, `TPW_M_FAST9, `TPW_M_FAST10, `TPW_M_FAST_CAP, `TPW_M_FAST_CMPA};
    assign clr_ovf = avs_write && !avs_waitrequest && avs_address == `TPW_OFF_FLAGS
                     && avs_byteenable[0] && avs_writedata[0];

    bus_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    unmapped_rd_a: assert property (avs_read && !avs_waitrequest && avs_address == 5'h1c
        |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
    pin_enable_a: assert property (pin_oe_n == {!(ctrl_state.pin_direction_bit[1]
        && ctrl_state.channel_b_output_select != 2'h0), !(ctrl_state.pin_direction_bit[0]
        && ctrl_state.channel_a_output_select != 2'h0)}) else $error("pin enable wrong");
    idle_chan_a: assert property ((ctrl_state.channel_a_output_select == `TPW_SEL_NONE)[*2]
        |=> $stable(pin_out[0])) else $error("idle channel output moved");
    tick_only_a: assert property ($changed(pin_out) |-> $past(timer_tick))
        else $error("output moved without a tick");
    flag_sticky_a: assert property (flag_state.overflow_flag && !clr_ovf |=> flag_state.overflow_flag)
        else $error("overflow flag lost");
    flag_tick_a: assert property ($rose(flag_state.overflow_flag) |-> $past(timer_tick))
        else $error("overflow flag without a tick");
    cap_top_a: assert property ($rose(flag_state.overflow_flag)
        && $past(ctrl_state.waveform_mode_select) == `TPW_M_FAST_CAP |-> flag_state.capture_flag)
        else $error("capture flag missing at top");
    bottom_set_a: assert property ($rose(flag_state.overflow_flag) && $past(fast_m)
        && $past(ctrl_state.channel_a_output_select) == 2'h2 |-> pin_out[0])
        else $error("output not set at bottom");

    // main scenarios reached
    cover property ($rose(flag_state.overflow_flag));
    cover property ($rose(flag_state.capture_flag));
    cover property ($fell(pin_out[1]));
endmodule : tpw_timer16_asserts

bind tpw_timer16 tpw_timer16_asserts i_chk (.sys_clk, .rstn, .timer_tick, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_out,
    .pin_oe_n, .ctrl_state, .flag_state);

// ### tb/tpw_load_model.sv
// load on the compare pins, with a pull-down
`timescale 1ns/1ns

module tpw_load_model (
    // pin side of the timer
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    // level seen by the load
    output logic     [1:0] pin_level
);
    // direction gates pin
    // a released pin sinks to the pull-down, never keeps the last driven value
    assign pin_level = pin_out & ~pin_oe_n;
endmodule : tpw_load_model

// ### tb/test_tpw_timer16.sv
// self-checking bench for the pwm timer
`timescale 1ns/1ns
`include "tpw_defines.svh"

module test_tpw_timer16;
    import tpw_pkg::*;

    logic                sys_clk;
    logic                rstn;
    logic                timer_tick;
    logic [4:0]          avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [31:0]         avs_writedata;
    logic [3:0]          avs_byteenable;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic [1:0]          pin_out;
    logic [1:0]          pin_oe_n;
    logic [1:0]          pin_level;
    tpw_pkg::tpw_ctrl_t  ctrl_state;
    tpw_pkg::tpw_flags_t flag_state;
    logic [31:0]         exp_q[$];
    logic [31:0]         rnd_b;
    int                  n_fail;
    int                  n_tests;
    int                  n_cyc;

    tpw_timer16 i_dut (.sys_clk, .rstn, .timer_tick, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_out, .pin_oe_n,
        .ctrl_state, .flag_state);
    tpw_load_model i_load (.pin_out, .pin_oe_n, .pin_level);

    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= rd;
        avs_write     <= !rd;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask : wr

    // expectation is queued before the read so the monitor always finds it
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0000_0000);
    endtask : rd

    // exactly n timer ticks; the counter holds while the bus is used
    task automatic ticks(input int n);
        @(posedge sys_clk);
        timer_tick <= 1'b1;
        repeat (n) @(posedge sys_clk);
        timer_tick <= 1'b0;
    endtask : ticks

    // read data monitor against the oldest expectation
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            check(avs_readdata, exp_q.pop_front());
        end
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        n_cyc++;
        if (n_cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        timer_tick = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        n_fail = 0;
        n_tests = 0;
        n_cyc = 0;
        void'($urandom(32'h0000_be44));
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        // reset state and unmapped place
        rd(`TPW_OFF_CTRL, 32'h0000_0000);
        rd(`TPW_OFF_CAPTOP, 32'h0000_ffff);
        rd(5'h1c, 32'h0000_0000);
        check({30'h0, pin_oe_n}, 32'h0000_0003);
        $display("test 1 done");
        // fast 8-bit: b inverted with random compare, a non-inverted
        wr(`TPW_OFF_CMPA, 32'h0000_0010);
        wr(`TPW_OFF_CTRL, 32'h0000_03e5);
        rnd_b = $urandom;
        wr(`TPW_OFF_CMPB, rnd_b);
        rd(`TPW_OFF_CMPB, rnd_b & 32'h0000_00ff);
        ticks(16);
        rd(`TPW_OFF_STATUS, 32'h0000_0002);
        rd(`TPW_OFF_FLAGS, 32'h0000_0004);
        ticks(1);
        rd(`TPW_OFF_FLAGS, 32'h0000_0006);
        ticks(239);
        rd(`TPW_OFF_COUNT, 32'h0000_0000);
        rd(`TPW_OFF_STATUS, 32'h0000_0001);
        rd(`TPW_OFF_FLAGS, 32'h0000_0007);
        wr(`TPW_OFF_FLAGS, 32'h0000_000f);
        ticks(17);
        rd(`TPW_OFF_STATUS, {30'h0, rnd_b[7:0] <= 8'h10, 1'b0});
        rd(`TPW_OFF_COUNT, 32'h0000_0011);
        $display("test 2 done");
        // fast with capture top written below the count
        wr(`TPW_OFF_CTRL, 32'h0000_012e);
        wr(`TPW_OFF_COUNT, 32'h0000_0020);
        wr(`TPW_OFF_CAPTOP, 32'h0000_0011);
        wr(`TPW_OFF_FLAGS, 32'h0000_000f);
        ticks(1);
        rd(`TPW_OFF_COUNT, 32'h0000_0021);
        wr(`TPW_OFF_COUNT, 32'h0000_fffe);
        ticks(2);
        rd(`TPW_OFF_COUNT, 32'h0000_0000);
        rd(`TPW_OFF_FLAGS, {29'h0, rnd_b[7:0] == 8'h20, 2'b00});
        wr(`TPW_OFF_FLAGS, 32'h0000_000f);
        ticks(18);
        rd(`TPW_OFF_FLAGS, {28'h0, 1'b1, rnd_b[7:0] <= 8'h11, 2'b11});
        rd(`TPW_OFF_COUNT, 32'h0000_0000);
        check({30'h0, pin_level}, 32'h0000_0001);
        $display("test 3 done");
        // phase correct with compare a as top, b non-inverted at 2
        wr(`TPW_OFF_CTRL, 32'h0000_0000);
        wr(`TPW_OFF_CMPA, 32'h0000_0006);
        wr(`TPW_OFF_CMPB, 32'h0000_0002);
        wr(`TPW_OFF_COUNT, 32'h0000_0000);
        wr(`TPW_OFF_CTRL, 32'h0000_028b);
        wr(`TPW_OFF_FLAGS, 32'h0000_000f);
        ticks(6);
        rd(`TPW_OFF_COUNT, 32'h0000_0006);
        rd(`TPW_OFF_STATUS, 32'h0000_0001);
        ticks(1);
        rd(`TPW_OFF_COUNT, 32'h0000_0005);
        rd(`TPW_OFF_STATUS, 32'h0000_0005);
        ticks(4);
        rd(`TPW_OFF_STATUS, 32'h0000_0007);
        check({30'h0, pin_level}, 32'h0000_0002);
        ticks(2);
        rd(`TPW_OFF_COUNT, 32'h0000_0001);
        rd(`TPW_OFF_FLAGS, 32'h0000_0007);
        rd(`TPW_OFF_STATUS, 32'h0000_0003);
        $display("test 4 done");
        // legal tops, moved only in single slope
        wr(`TPW_OFF_CTRL, 32'h0000_011f);
        wr(`TPW_OFF_CMPA, 32'h0000_0004);
        wr(`TPW_OFF_FLAGS, 32'h0000_000f);
        ticks(6);
        rd(`TPW_OFF_COUNT, 32'h0000_0000);
        rd(`TPW_OFF_STATUS, 32'h0000_0002);
        rd(`TPW_OFF_FLAGS, 32'h0000_0007);
        check({28'h000_0000, flag_state}, 32'h0000_0007);
        check({22'h00_0000, ctrl_state}, 32'h0000_011f);
        ticks(5);
        rd(`TPW_OFF_STATUS, 32'h0000_0003);
        wr(`TPW_OFF_CTRL, 32'h0000_0003);
        wr(`TPW_OFF_CMPB, rnd_b);
        rd(`TPW_OFF_CMPB, rnd_b & 32'h0000_03ff);
        $display("test 5 done");
        give_verdict();
    end
endmodule : test_tpw_timer16
